// [rtl/sbg_pkg.sv]
// Package for the serial port bit rate timer: register map, fields and resets
package sbg_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] SBG_IDX_RCV_CTRL = 8'h18;
    localparam logic [7:0] SBG_IDX_XMT_CTRL = 8'h98;
    localparam logic [7:0] SBG_IDX_DIVISOR = 8'h99;
    localparam logic [7:0] SBG_IDX_IRQ_STATUS = 8'h9A;
    localparam logic [7:0] SBG_IDX_IRQ_MASK = 8'h9B;
    localparam logic [9:0] SBG_OFF_RCV_CTRL = {SBG_IDX_RCV_CTRL, 2'h0};
    localparam logic [9:0] SBG_OFF_XMT_CTRL = {SBG_IDX_XMT_CTRL, 2'h0};
    localparam logic [9:0] SBG_OFF_DIVISOR = {SBG_IDX_DIVISOR, 2'h0};
    localparam logic [9:0] SBG_OFF_IRQ_STATUS = {SBG_IDX_IRQ_STATUS, 2'h0};
    localparam logic [9:0] SBG_OFF_IRQ_MASK = {SBG_IDX_IRQ_MASK, 2'h0};
    localparam logic [7:0] SBG_RST_XMT_CTRL = 8'h02;
    localparam logic [7:0] SBG_RST_DIVISOR = 8'h00;
    localparam logic [7:0] SBG_RST_RCV_CTRL = 8'h00;
    localparam int SBG_XMT_CLK_MASTER = 7;
    localparam int SBG_XMT_SYNC = 4;
    localparam int SBG_XMT_HIGH_SPEED = 2;
    localparam int SBG_XMT_SHIFT_EMPTY = 1;
    localparam int SBG_RCV_CONT_ENABLE = 4;
    localparam int SBG_RCV_FRAMING = 2;
    localparam int SBG_RCV_OVERRUN = 1;
    localparam int SBG_RCV_NINTH = 0;
    localparam logic [7:0] SBG_RCV_WRITABLE = 8'hF8;
    localparam logic [7:0] SBG_XMT_WRITABLE = 8'hF5;
    localparam int SBG_IRQ_FRAMING = 0;
    localparam int SBG_IRQ_OVERRUN = 1;
    localparam logic [1:0] SBG_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBG_RESP_SLVERR = 2'h2;
    localparam logic [5:0] SBG_PRESCALE_ASYNC_LOW = 6'h3F;
    localparam logic [5:0] SBG_PRESCALE_ASYNC_HIGH = 6'h0F;
    localparam logic [5:0] SBG_PRESCALE_SYNC = 6'h03;
    typedef struct packed {
        logic valid;
        logic framing_bad;
        logic ninth_bit;
        logic overrun;
    } sbg_rx_event_t;
endpackage

// [rtl/sbg_bit_rate.sv]
// Bit rate timer with AXI4-Lite registers, receive fault flags and interrupt
`timescale 1ns/1ps
module sbg_bit_rate (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sbg_pkg::sbg_rx_event_t rx_event,
    input wire logic shift_empty,
    output logic receive_buffer_read,
    output logic baud_tick,
    output logic continuous_receive_enable,
    output logic irq
);
    import sbg_pkg::*;

    logic [7:0] xmt_ctrl;
    logic [7:0] rcv_ctrl_hi;
    logic [7:0] baud_divisor_register;
    logic [7:0] bit_rate_timer;
    logic [5:0] prescale;
    logic framing_fault_flag;
    logic overrun_fault_flag;
    logic received_ninth_bit;
    logic framing_armed;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // Write channel: address and data may arrive in either order
    logic aw_held;
    logic w_held;
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held || aw_take;
    wire w_have = w_held || w_take;
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire [9:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire wr_lane = w_held ? w_lane0 : s_axi_wstrb[0];

    function automatic logic known_addr(input logic [9:0] a);
        return a == SBG_OFF_RCV_CTRL || a == SBG_OFF_XMT_CTRL || a == SBG_OFF_DIVISOR ||
               a == SBG_OFF_IRQ_STATUS || a == SBG_OFF_IRQ_MASK;
    endfunction

    wire wr_ok = known_addr(wr_addr);
    wire wr_en = do_write && wr_ok && wr_lane;
    wire wr_rcv = wr_en && wr_addr == SBG_OFF_RCV_CTRL;
    wire wr_xmt = wr_en && wr_addr == SBG_OFF_XMT_CTRL;
    wire wr_div = wr_en && wr_addr == SBG_OFF_DIVISOR;
    wire wr_ists = wr_en && wr_addr == SBG_OFF_IRQ_STATUS;
    wire wr_imask = wr_en && wr_addr == SBG_OFF_IRQ_MASK;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 10'h000;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SBG_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            aw_held <= do_write ? 1'b0 : aw_have;
            w_held <= do_write ? 1'b0 : w_have;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? SBG_RESP_OKAY : SBG_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write channel checks
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_bvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeated");
    a_write_block: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid) else $error("write not answered");
    a_write_error: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && !wr_ok |=> s_axi_bresp == SBG_RESP_SLVERR) else $error("unmapped write accepted");

    // Control registers
    wire clk_master = xmt_ctrl[SBG_XMT_CLK_MASTER];
    wire sync_mode = xmt_ctrl[SBG_XMT_SYNC];
    wire high_speed_select = xmt_ctrl[SBG_XMT_HIGH_SPEED];
    assign continuous_receive_enable = rcv_ctrl_hi[SBG_RCV_CONT_ENABLE];
    wire receive_disable_write = wr_rcv && !wr_data[SBG_RCV_CONT_ENABLE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xmt_ctrl <= SBG_RST_XMT_CTRL & SBG_XMT_WRITABLE;
            rcv_ctrl_hi <= SBG_RST_RCV_CTRL;
            baud_divisor_register <= SBG_RST_DIVISOR;
            irq_mask <= 2'h0;
        end else begin
            if (wr_xmt) begin
                xmt_ctrl <= wr_data[7:0] & SBG_XMT_WRITABLE;
            end
            if (wr_rcv) begin
                rcv_ctrl_hi <= wr_data[7:0] & SBG_RCV_WRITABLE;
            end
            if (wr_div) begin
                baud_divisor_register <= wr_data[7:0];
            end
            if (wr_imask) begin
                irq_mask <= wr_data[1:0];
            end
        end
    end

    // Register store checks
    a_xmt_store: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_xmt |=> xmt_ctrl == ($past(wr_data[7:0]) & SBG_XMT_WRITABLE)) else $error("xmt ctrl not stored");
    a_rcv_store: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_rcv |=> rcv_ctrl_hi == ($past(wr_data[7:0]) & SBG_RCV_WRITABLE)) else $error("rcv ctrl not stored");
    a_mask_store: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_imask |=> irq_mask == $past(wr_data[1:0])) else $error("irq mask not stored");
    a_div_lane: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wr_addr == SBG_OFF_DIVISOR && !wr_lane |=> $stable(baud_divisor_register))
        else $error("divisor changed without lane");

    // Prescale per mode; sync mode never looks at high speed select
    wire [5:0] prescale_top = sync_mode ? SBG_PRESCALE_SYNC :
                              (high_speed_select ? SBG_PRESCALE_ASYNC_HIGH : SBG_PRESCALE_ASYNC_LOW);
    wire pre_wrap = prescale >= prescale_top;
    wire timer_wrap = pre_wrap && bit_rate_timer == 8'h00;
    wire run = clk_master;

    // Timer counts down from divisor, one tick each (divisor+1) prescaled periods
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= 6'h00;
            bit_rate_timer <= 8'h00;
            baud_tick <= 1'b0;
        end else if (wr_div || !run) begin
            prescale <= 6'h00;
            bit_rate_timer <= wr_div ? wr_data[7:0] : baud_divisor_register;
            baud_tick <= 1'b0;
        end else begin
            prescale <= pre_wrap ? 6'h00 : prescale + 6'h01;
            if (pre_wrap) begin
                bit_rate_timer <= timer_wrap ? baud_divisor_register : bit_rate_timer - 8'h01;
            end
            baud_tick <= timer_wrap;
        end
    end

    // Cycle counter between ticks lets the rate be checked without long repetitions
    logic [14:0] tick_gap;
    logic gap_valid;
    function automatic logic [14:0] rate_period(input logic sync_sel, input logic fast_sel, input logic [7:0] div);
        logic [5:0] top;
        top = sync_sel ? SBG_PRESCALE_SYNC : (fast_sel ? SBG_PRESCALE_ASYNC_HIGH : SBG_PRESCALE_ASYNC_LOW);
        return ({9'h000, top} + 15'h0001) * ({7'h00, div} + 15'h0001);
    endfunction

    // Any rate change voids the measurement until the next clean tick
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_div || wr_xmt || !run) begin
            tick_gap <= 15'h0000;
            gap_valid <= 1'b0;
        end else if (baud_tick) begin
            tick_gap <= 15'h0001;
            gap_valid <= 1'b1;
        end else begin
            tick_gap <= (&tick_gap) ? tick_gap : tick_gap + 15'h0001;
        end
    end

    a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_tick && gap_valid |-> tick_gap == rate_period(sync_mode, high_speed_select, baud_divisor_register))
        else $error("tick period wrong");
    a_sync_fast: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_mode && high_speed_select |-> prescale_top == SBG_PRESCALE_SYNC) else $error("high speed used in sync");
    a_timer_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_rate_timer <= baud_divisor_register) else $error("timer above divisor");
    a_timer_step: assert property (@(posedge aclk) disable iff (!aresetn)
        run && !wr_div && pre_wrap && bit_rate_timer != 8'h00 |=> bit_rate_timer == $past(bit_rate_timer) - 8'h01)
        else $error("timer did not count down");
    a_timer_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        run && !wr_div && timer_wrap |=> bit_rate_timer == $past(baud_divisor_register)) else $error("timer not reloaded");
    a_tick_timer: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_tick |-> bit_rate_timer == baud_divisor_register) else $error("tick without reload");
    a_prescale_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_tick |-> prescale == 6'h00) else $error("prescale not cleared at tick");
    a_tick_master: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_tick |-> $past(clk_master)) else $error("tick while not master");
    a_gap_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        gap_valid |-> tick_gap <= 15'h4000) else $error("tick gap too long");

    // Receive fault flags
    wire rd_rcv_buf;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            framing_fault_flag <= 1'b0;
            framing_armed <= 1'b1;
            overrun_fault_flag <= 1'b0;
            received_ninth_bit <= 1'b0;
        end else begin
            if (rd_rcv_buf) begin
                framing_armed <= 1'b1;
            end else if (rx_event.valid && framing_armed) begin
                framing_armed <= 1'b0;
            end
            if (rx_event.valid && framing_armed) begin
                framing_fault_flag <= rx_event.framing_bad;
                received_ninth_bit <= rx_event.ninth_bit;
            end
            if (rx_event.overrun) begin
                overrun_fault_flag <= 1'b1;
            end else if (receive_disable_write) begin
                overrun_fault_flag <= 1'b0;
            end
        end
    end

    // Fault flag checks
    sequence s_frame_taken;
        rx_event.valid && framing_armed;
    endsequence
    a_framing_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !(rx_event.valid && framing_armed) |=> $stable(framing_fault_flag)) else $error("framing flag moved");
    a_ninth_load: assert property (@(posedge aclk) disable iff (!aresetn)
        s_frame_taken |=> received_ninth_bit == $past(rx_event.ninth_bit)) else $error("ninth bit not loaded");
    a_armed_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        s_frame_taken ##0 !rd_rcv_buf |=> !framing_armed) else $error("framing flag still armed");
    a_framing_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        s_frame_taken ##0 rx_event.framing_bad |=> irq_status[SBG_IRQ_FRAMING]) else $error("framing event lost");
    a_overrun_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        receive_disable_write && !rx_event.overrun |=> !overrun_fault_flag) else $error("overrun not cleared");

    // Sticky interrupt status, write one to clear, a new event wins
    wire [1:0] irq_set = {rx_event.overrun, rx_event.valid && framing_armed && rx_event.framing_bad};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= irq_set | (irq_status & ~(wr_ists ? wr_data[1:0] : 2'h0));
        end
    end
    assign irq = |(irq_status & irq_mask);

    // Interrupt checks
    a_status_set: assert property (@(posedge aclk) disable iff (!aresetn)
        |irq_set |=> (irq_status & $past(irq_set)) == $past(irq_set)) else $error("status event lost");
    a_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ists && irq_set == 2'h0 |=> (irq_status & $past(wr_data[1:0])) == 2'h0) else $error("status not cleared");
    a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_mask == 2'h0 |-> !irq) else $error("irq while fully masked");

    // Read channel
    wire ar_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;
    wire [7:0] rcv_view = rcv_ctrl_hi | {5'h00, framing_fault_flag, overrun_fault_flag, received_ninth_bit};
    wire [7:0] xmt_view = xmt_ctrl | {6'h00, shift_empty, 1'b0};
    wire [7:0] rd_byte = s_axi_araddr == SBG_OFF_RCV_CTRL ? rcv_view :
                         s_axi_araddr == SBG_OFF_XMT_CTRL ? xmt_view :
                         s_axi_araddr == SBG_OFF_DIVISOR ? baud_divisor_register :
                         s_axi_araddr == SBG_OFF_IRQ_STATUS ? {6'h00, irq_status} :
                         s_axi_araddr == SBG_OFF_IRQ_MASK ? {6'h00, irq_mask} : 8'h00;
    assign rd_rcv_buf = 1'b0;
    assign receive_buffer_read = rd_rcv_buf;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SBG_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= known_addr(s_axi_araddr) ? SBG_RESP_OKAY : SBG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Read channel checks
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_rvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data repeated");
    a_ar_block: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken during answer");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take |=> s_axi_rvalid) else $error("read not answered");
    a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_read_error: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && !known_addr(s_axi_araddr) |=> s_axi_rresp == SBG_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read accepted");

    // Checks
    sequence s_div_write;
        wr_div;
    endsequence
    a_div_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        s_div_write |=> prescale == 6'h00 && !baud_tick) else $error("divisor write did not restart timer");
    a_sync_prescale: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_mode |-> prescale_top == 6'h03) else $error("sync prescale wrong");
    a_async_prescale: assert property (@(posedge aclk) disable iff (!aresetn)
        !sync_mode |-> prescale_top == (high_speed_select ? 6'h0F : 6'h3F)) else $error("async prescale wrong");
    a_idle_slave: assert property (@(posedge aclk) disable iff (!aresetn)
        !clk_master |=> !baud_tick) else $error("tick without internal clock");
    a_tick_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_tick |-> $past(bit_rate_timer) == 8'h00) else $error("tick without timer wrap");
    a_tick_single: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_tick |=> !baud_tick) else $error("tick longer than one cycle");
    a_overrun_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        overrun_fault_flag && !receive_disable_write |=> overrun_fault_flag) else $error("overrun lost");
    a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_event.overrun |=> overrun_fault_flag && irq_status[1]) else $error("overrun not flagged");
    a_framing_load: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_event.valid && framing_armed |=> framing_fault_flag == $past(rx_event.framing_bad))
        else $error("framing flag not refreshed");
    a_div_range: assert property (@(posedge aclk) disable iff (!aresetn)
        s_div_write |=> baud_divisor_register == $past(wr_data[7:0])) else $error("divisor not stored");
endmodule

// [bench/test_sbg_bit_rate.sv]
// Register-level testbench for the bit rate timer block
`timescale 1ns/1ps
module test_sbg_bit_rate;
    import sbg_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    sbg_rx_event_t rx_event;
    logic shift_empty, receive_buffer_read, baud_tick, continuous_receive_enable, irq;
    int miscompares, checked, n;
    logic [7:0] mode [4] = '{8'h80, 8'h84, 8'h90, 8'h94};
    int pre [4] = '{64, 16, 4, 4};
    logic [7:0] dv [3] = '{8'h00, 8'h02, 8'hFF};
    sbg_bit_rate dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .rx_event(rx_event), .shift_empty(shift_empty), .receive_buffer_read(receive_buffer_read),
        .baud_tick(baud_tick), .continuous_receive_enable(continuous_receive_enable), .irq(irq));
    task automatic final_report();
        $display("Checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic limit(input int k, input int lim);
        if (k >= lim) begin
            miscompares++;
            $display("Error wait cycles expected below %0d seen %0d", lim, k);
            final_report();
        end
    endtask
    task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && k < 100);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        limit(k, 100);
    endtask
    task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        limit(k, 100);
    endtask
    // Counts edges up to and including the next tick
    task automatic wait_tick(input int lim, output int k);
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (baud_tick !== 1'b1 && k < lim);
        limit(k, lim);
    endtask
    task automatic rx_pulse(input logic [3:0] ev);
        rx_event <= ev;
        @(posedge aclk);
        rx_event <= 4'h0;
        @(posedge aclk);
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
        s_axi_wstrb = 4'hF;
        rx_event = 4'h0;
        shift_empty = 1'b1;
        miscompares = 0;
        checked = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(SBG_OFF_XMT_CTRL, rd, rsp);
        chk("xmt ctrl reset", 32'h02, rd);
        axi_rd(SBG_OFF_DIVISOR, rd, rsp);
        chk("divisor reset", 32'h00, rd);
        axi_rd(SBG_OFF_RCV_CTRL, rd, rsp);
        chk("rcv ctrl reset", 32'h00, rd);
        axi_rd(10'h040, rd, rsp);
        chk("unmapped read resp", SBG_RESP_SLVERR, rsp);
        chk("unmapped read data", 32'h0, rd);
        axi_wr(10'h040, 32'h1, rsp);
        chk("unmapped write", SBG_RESP_SLVERR, rsp);
        axi_wr(SBG_OFF_DIVISOR, 32'h123456A5, rsp);
        axi_rd(SBG_OFF_DIVISOR, rd, rsp);
        chk("divisor readback", 32'hA5, rd);
        for (int m = 0; m < 4; m++) begin
            for (int j = 0; j < 3; j++) begin
                axi_wr(SBG_OFF_XMT_CTRL, {24'h0, mode[m]}, rsp);
                axi_wr(SBG_OFF_DIVISOR, {24'h0, dv[j]}, rsp);
                wait_tick(20000, n);
                wait_tick(20000, n);
                chk("tick period", pre[m] * (dv[j] + 1), n);
            end
        end
        // Internal clock master off: the timer must stay silent
        axi_wr(SBG_OFF_XMT_CTRL, 32'h04, rsp);
        axi_wr(SBG_OFF_DIVISOR, 32'h00, rsp);
        n = 0;
        repeat (200) begin
            @(posedge aclk);
            n += int'(baud_tick === 1'b1);
        end
        chk("ticks without master", 0, n);
        axi_wr(SBG_OFF_XMT_CTRL, 32'h90, rsp);
        axi_wr(SBG_OFF_DIVISOR, 32'd200, rsp);
        wait_tick(2000, n);
        repeat (100) @(posedge aclk);
        axi_wr(SBG_OFF_DIVISOR, 32'h01, rsp);
        wait_tick(2000, n);
        chk("tick soon after divisor write", 1, n <= 10);
        wait_tick(2000, n);
        chk("period after divisor write", 8, n);
        axi_rd(SBG_OFF_XMT_CTRL, rd, rsp);
        chk("xmt ctrl shift empty", 32'h92, rd);
        shift_empty <= 1'b0;
        axi_rd(SBG_OFF_XMT_CTRL, rd, rsp);
        chk("xmt ctrl shift busy", 32'h90, rd);
        axi_wr(SBG_OFF_IRQ_MASK, 32'h3, rsp);
        axi_wr(SBG_OFF_RCV_CTRL, 32'h10, rsp);
        chk("receive enable", 1, continuous_receive_enable);
        rx_pulse(4'hE);
        axi_rd(SBG_OFF_RCV_CTRL, rd, rsp);
        chk("framing and ninth bit", 32'h15, rd);
        chk("irq framing", 1, irq);
        rx_pulse(4'h1);
        axi_rd(SBG_OFF_RCV_CTRL, rd, rsp);
        chk("overrun set", 32'h17, rd);
        axi_rd(SBG_OFF_IRQ_STATUS, rd, rsp);
        chk("irq status", 32'h3, rd);
        axi_wr(SBG_OFF_IRQ_STATUS, 32'h1, rsp);
        axi_rd(SBG_OFF_IRQ_STATUS, rd, rsp);
        chk("status after clear", 32'h2, rd);
        axi_wr(SBG_OFF_IRQ_MASK, 32'h1, rsp);
        @(posedge aclk);
        chk("irq masked", 0, irq);
        axi_wr(SBG_OFF_IRQ_MASK, 32'h2, rsp);
        @(posedge aclk);
        chk("irq unmasked", 1, irq);
        axi_wr(SBG_OFF_RCV_CTRL, 32'h00, rsp);
        axi_rd(SBG_OFF_RCV_CTRL, rd, rsp);
        chk("overrun cleared", 32'h05, rd);
        chk("receive disabled", 0, continuous_receive_enable);
        axi_wr(SBG_OFF_IRQ_STATUS, 32'h2, rsp);
        @(posedge aclk);
        chk("irq after clear", 0, irq);
        chk("buffer read strobe", 0, receive_buffer_read);
        final_report();
    end
endmodule
